// [hdl/dual_timer.sv]
// Two 8-bit timer/counters, chainable to 16 bits, with capture, compare and 10-bit PWM.
// Contract
// - Timer A divides by 2..2048 via three bits; timer B by 1, 2, 8.
// - Timer A select 111 counts rising edges of the event pin; timer B never.
// - 8-bit counters run from zero to match, then wrap; A match sets A flag.
// - Data address reads the running count and writes the match value.
// - Mode comes from chain, captures, PWM enable, timer B select and pin select; seven modes.
// - Chained counter runs to combined match then zero; only A flag rises.
// - Compare output toggles the wave pin on every timer B match and every chained match, not on 8-bit timer A matches.
// - Each timer's capture is enabled by its own mode register bit; in 8-bit modes PWM blocks both and A's bit blocks B's.
// - Capture mode keeps counting and still raises the match flag.
// - Trigger edge copies count to capture register, clears and restarts the counter.
// - Trigger edge is falling, rising or both; each one sets an external flag.
// - In capture mode the data address reads the capture register.
// - Chained capture works on the full 16-bit count and capture value.
// - PWM period and duty are ten bits, high bits from the high register.
// - New duty moves to the active stage only at the period match.
// - Polarity bit sets the active level; duty at period or zero is constant.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "dtc_params.svh"
module dual_timer (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire dtc_pkg::addr_t ADDR,
  input wire dtc_pkg::byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output dtc_pkg::byte_t RDATA,
  input wire logic EVENT_CLOCK_PIN,
  input wire logic CAPTURE_TRIGGER_PIN_A,
  input wire logic CAPTURE_TRIGGER_PIN_B,
  output logic TIMER_A_FLAG,
  output logic TIMER_B_FLAG,
  output logic EXT_A_FLAG,
  output logic EXT_B_FLAG,
  output logic COMPARE_WAVE_PIN,
  output logic COMPARE_WAVE_OE_N
);
  import dtc_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // A prescaler tap of ratio 2**k fires when the low k bits are all ones.
  function automatic logic div_tick(input logic [10:0] p, input logic [3:0] k);
    logic [10:0] m;
    m = 11'((12'h001 << k) - 12'h001);
    return (p & m) == m;
  endfunction

  function automatic logic [3:0] a_shift(input logic [2:0] sel);
    case (sel)
      3'h0: a_shift = `SH1;
      3'h1: a_shift = `SH2;
      3'h2: a_shift = `SH3;
      3'h3: a_shift = `SH5;
      3'h4: a_shift = `SH7;
      3'h5: a_shift = `SH9;
      default: a_shift = `SH11;
    endcase
  endfunction

  function automatic logic [3:0] b_shift(input logic [1:0] sel);
    case (sel)
      2'h0: b_shift = `SH0;
      2'h1: b_shift = `SH1;
      default: b_shift = `SH3;
    endcase
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[`EDGE_RISE_BIT] & r) | (sel[`EDGE_FALL_BIT] & f);
  endfunction

  function automatic mode_t decode_mode(input byte_t am, input byte_t bm, input byte_t pb);
    logic chain;
    chain = bm[`CHAIN_BIT] && bm[`B_CS_MSB:`B_CS_LSB] == `B_CHAIN_SEL;
    if (chain) begin
      if (am[`A_CAP_BIT])
        decode_mode = MODE_CAP16;
      else if (pb[`PB_WAVE_BIT])
        decode_mode = MODE_CMP16;
      else
        decode_mode = MODE_TIMER16;
    end else if (bm[`PWM_ENABLE_BIT]) begin
      decode_mode = MODE_PWM;
    end else if (am[`A_CAP_BIT]) begin
      decode_mode = MODE_ACAP8;
    end else if (bm[`B_CAP_BIT]) begin
      decode_mode = MODE_BCAP8;
    end else begin
      decode_mode = MODE_TIMER8;
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic ev_rise, ta_rise, ta_fall, tb_rise, tb_fall;
  pin_sync u_ev (.clk(CLK_SYS), .rst(RESET), .pin(EVENT_CLOCK_PIN), .rise(ev_rise), .fall());
  pin_sync u_ta (.clk(CLK_SYS), .rst(RESET), .pin(CAPTURE_TRIGGER_PIN_A), .rise(ta_rise), .fall(ta_fall));
  pin_sync u_tb (.clk(CLK_SYS), .rst(RESET), .pin(CAPTURE_TRIGGER_PIN_B), .rise(tb_rise), .fall(tb_fall));

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  byte_t amode_q, amode_d, bmode_q, bmode_d, mat_a_q, mat_a_d, mat_b_q, mat_b_d;
  byte_t per_lo_q, per_lo_d, duty_lo_q, duty_lo_d, high_q, high_d;
  byte_t portb_q, portb_d, porta_q, porta_d, edge_q, edge_d, rdata_q, rdata_d;
  byte_t flags_q, flags_d, cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d, cap_a_q, cap_a_d, cap_b_q, cap_b_d;
  logic [10:0] pre_q, pre_d;
  logic [9:0] pc_q, pc_d, duty_act_q, duty_act_d;
  logic tog_q, tog_d, pin_q, pin_d, oe_n_q, oe_n_d;
  mode_t mode;
  logic chain_on, cap_a_on, cap_b_on, pwm_on, a_inc, b_inc, trig_a, trig_b;
  logic [15:0] cnt16, mat16;
  logic [9:0] period, duty_hold;

  assign mode = decode_mode(amode_q, bmode_q, portb_q);
  assign chain_on = mode == MODE_TIMER16 || mode == MODE_CAP16 || mode == MODE_CMP16;
  assign cap_a_on = mode == MODE_ACAP8 || mode == MODE_CAP16;
  assign cap_b_on = mode == MODE_BCAP8;
  assign pwm_on = mode == MODE_PWM;
  assign cnt16 = {cnt_b_q, cnt_a_q};
  assign mat16 = {mat_b_q, mat_a_q};
  assign period = {high_q[`HI_PER_MSB:`HI_PER_LSB], per_lo_q};
  assign duty_hold = {high_q[`HI_DUTY_MSB:`HI_DUTY_LSB], duty_lo_q};

  // Event counting is allowed only while the pin's direction bit says input.
  assign a_inc = (amode_q[`A_CS_MSB:`A_CS_LSB] == `A_EVENT_SEL)
    ? (ev_rise & ~porta_q[`PA_EVENT_BIT])
    : div_tick(pre_q, a_shift(amode_q[`A_CS_MSB:`A_CS_LSB]));
  assign b_inc = (bmode_q[`B_CS_MSB:`B_CS_LSB] != `B_CHAIN_SEL)
    && div_tick(pre_q, b_shift(bmode_q[`B_CS_MSB:`B_CS_LSB]));
  assign trig_a = portb_q[`PB_INTA_BIT] && edge_hit(edge_q[`EDGE_A_MSB:`EDGE_A_LSB], ta_rise, ta_fall);
  assign trig_b = portb_q[`PB_INTB_BIT] && edge_hit(edge_q[`EDGE_B_MSB:`EDGE_B_LSB], tb_rise, tb_fall);

  always_comb begin
    amode_d = amode_q;
    bmode_d = bmode_q;
    mat_a_d = mat_a_q;
    mat_b_d = mat_b_q;
    per_lo_d = per_lo_q;
    duty_lo_d = duty_lo_q;
    high_d = high_q;
    portb_d = portb_q;
    porta_d = porta_q;
    edge_d = edge_q;
    rdata_d = `ZERO8;
    if (WR) begin
      case (ADDR)
        `A_MODE_ADR: amode_d = WDATA;
        `A_DATA_ADR: mat_a_d = WDATA;
        `B_MODE_ADR: bmode_d = WDATA;
        `B_DATA_ADR: mat_b_d = WDATA;
        `PER_LO_ADR: per_lo_d = WDATA;
        `DUTY_LO_ADR: duty_lo_d = WDATA;
        `HIGH_ADR: high_d = WDATA;
        `PORTB_ADR: portb_d = WDATA;
        `PORTA_ADR: porta_d = WDATA;
        `EDGE_ADR: edge_d = WDATA;
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        `A_MODE_ADR: rdata_d = amode_q;
        `A_DATA_ADR: rdata_d = cap_a_on ? cap_a_q : cnt_a_q;
        `B_MODE_ADR: rdata_d = bmode_q;
        `B_DATA_ADR: rdata_d = (cap_b_on || mode == MODE_CAP16) ? cap_b_q : cnt_b_q;
        `PER_LO_ADR: rdata_d = per_lo_q;
        `DUTY_LO_ADR: rdata_d = duty_lo_q;
        `HIGH_ADR: rdata_d = high_q;
        `PORTB_ADR: rdata_d = portb_q;
        `PORTA_ADR: rdata_d = porta_q;
        `EDGE_ADR: rdata_d = edge_q;
        `STAT_ADR: rdata_d = flags_q;
        default: rdata_d = `ZERO8;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      amode_q <= `ZERO8;
      bmode_q <= `ZERO8;
      mat_a_q <= `MATCH_RST;
      mat_b_q <= `MATCH_RST;
      per_lo_q <= `ZERO8;
      duty_lo_q <= `ZERO8;
      high_q <= `ZERO8;
      portb_q <= `ZERO8;
      porta_q <= `ZERO8;
      edge_q <= `ZERO8;
      rdata_q <= `ZERO8;
    end else begin
      amode_q <= amode_d;
      bmode_q <= bmode_d;
      mat_a_q <= mat_a_d;
      mat_b_q <= mat_b_d;
      per_lo_q <= per_lo_d;
      duty_lo_q <= duty_lo_d;
      high_q <= high_d;
      portb_q <= portb_d;
      porta_q <= porta_d;
      edge_q <= edge_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // Counters, capture, flags and waveform
  // ------------------------------------------------------------
  // A capture edge wins over a count step in the same cycle, so the restart is exact.
  always_comb begin
    byte_t set;
    byte_t clr;
    set = `ZERO8;
    clr = (WR && ADDR == `STAT_ADR) ? WDATA : `ZERO8;
    pre_d = pre_q + `ONE11;
    cnt_a_d = cnt_a_q;
    cnt_b_d = cnt_b_q;
    cap_a_d = cap_a_q;
    cap_b_d = cap_b_q;
    pc_d = pc_q;
    duty_act_d = duty_act_q;
    tog_d = tog_q;
    set[`FL_XA_BIT] = trig_a;
    set[`FL_XB_BIT] = trig_b;
    if (chain_on) begin
      if (cap_a_on && trig_a) begin
        {cap_b_d, cap_a_d} = cnt16;
        {cnt_b_d, cnt_a_d} = `ZERO16;
      end else if (a_inc) begin
        if (cnt16 == mat16) begin
          {cnt_b_d, cnt_a_d} = `ZERO16;
          set[`FL_TA_BIT] = 1'b1;
          tog_d = ~tog_q;
        end else begin
          {cnt_b_d, cnt_a_d} = cnt16 + `ONE16;
        end
      end
    end else begin
      if (cap_a_on && trig_a) begin
        cap_a_d = cnt_a_q;
        cnt_a_d = `ZERO8;
      end else if (a_inc) begin
        if (cnt_a_q == mat_a_q) begin
          cnt_a_d = `ZERO8;
          set[`FL_TA_BIT] = 1'b1;
        end else begin
          cnt_a_d = cnt_a_q + `ONE8;
        end
      end
      if (pwm_on) begin
        if (b_inc) begin
          if (pc_q >= period) begin
            pc_d = `ZERO10;
            duty_act_d = duty_hold;
          end else begin
            pc_d = pc_q + `ONE10;
          end
        end
      end else if (cap_b_on && trig_b) begin
        cap_b_d = cnt_b_q;
        cnt_b_d = `ZERO8;
      end else if (b_inc) begin
        if (cnt_b_q == mat_b_q) begin
          cnt_b_d = `ZERO8;
          set[`FL_TB_BIT] = 1'b1;
          tog_d = ~tog_q;
        end else begin
          cnt_b_d = cnt_b_q + `ONE8;
        end
      end
    end
    flags_d = (flags_q & ~clr) | set;
  end

  always_comb begin
    logic act;
    act = (pc_q < duty_act_q) || (duty_act_q == period);
    oe_n_d = ~portb_q[`PB_WAVE_BIT];
    if (pwm_on)
      pin_d = act ? bmode_q[`POL_BIT] : ~bmode_q[`POL_BIT];
    else
      pin_d = tog_q;
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pre_q <= `ZERO11;
      cnt_a_q <= `ZERO8;
      cnt_b_q <= `ZERO8;
      cap_a_q <= `ZERO8;
      cap_b_q <= `ZERO8;
      pc_q <= `ZERO10;
      duty_act_q <= `ZERO10;
      tog_q <= 1'b0;
      flags_q <= `ZERO8;
      pin_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pre_q <= pre_d;
      cnt_a_q <= cnt_a_d;
      cnt_b_q <= cnt_b_d;
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
      pc_q <= pc_d;
      duty_act_q <= duty_act_d;
      tog_q <= tog_d;
      flags_q <= flags_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign RDATA = rdata_q;
  assign TIMER_A_FLAG = flags_q[`FL_TA_BIT];
  assign TIMER_B_FLAG = flags_q[`FL_TB_BIT];
  assign EXT_A_FLAG = flags_q[`FL_XA_BIT];
  assign EXT_B_FLAG = flags_q[`FL_XB_BIT];
  assign COMPARE_WAVE_PIN = pin_q;
  assign COMPARE_WAVE_OE_N = oe_n_q;
endmodule

// [hdl/dtc_params.svh]
// Register offsets, field positions, reset values and prescaler taps of the dual timer.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define A_MODE_ADR 4'h0
`define A_DATA_ADR 4'h1
`define B_MODE_ADR 4'h2
`define B_DATA_ADR 4'h3
`define PER_LO_ADR 4'h4
`define DUTY_LO_ADR 4'h5
`define HIGH_ADR 4'h6
`define PORTB_ADR 4'h7
`define PORTA_ADR 4'h8
`define EDGE_ADR 4'h9
`define STAT_ADR 4'hA
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define A_CS_MSB 2
`define A_CS_LSB 0
`define A_CAP_BIT 3
`define B_CS_MSB 1
`define B_CS_LSB 0
`define B_CAP_BIT 2
`define CHAIN_BIT 3
`define PWM_ENABLE_BIT 4
`define POL_BIT 5
`define PB_INTA_BIT 2
`define PB_INTB_BIT 3
`define PB_WAVE_BIT 4
`define PA_EVENT_BIT 0
`define FL_TA_BIT 0
`define FL_TB_BIT 1
`define FL_XA_BIT 2
`define FL_XB_BIT 3
`define EDGE_A_MSB 1
`define EDGE_A_LSB 0
`define EDGE_B_MSB 3
`define EDGE_B_LSB 2
`define EDGE_FALL_BIT 0
`define EDGE_RISE_BIT 1
`define HI_PER_MSB 3
`define HI_PER_LSB 2
`define HI_DUTY_MSB 1
`define HI_DUTY_LSB 0
// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define A_EVENT_SEL 3'h7
`define B_CHAIN_SEL 2'h3
`define ZERO8 8'h00
`define ZERO10 10'h000
`define ZERO11 11'h000
`define ZERO16 16'h0000
`define MATCH_RST 8'hFF
`define ONE8 8'h01
`define ONE10 10'h001
`define ONE11 11'h001
`define ONE16 16'h0001
`define SH0 4'h0
`define SH1 4'h1
`define SH2 4'h2
`define SH3 4'h3
`define SH5 4'h5
`define SH7 4'h7
`define SH9 4'h9
`define SH11 4'hB
`endif

// [hdl/dtc_pkg.sv]
// Types shared by the dual timer modules.
package dtc_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [6:0] {
    MODE_TIMER8 = 7'b000_0001,
    MODE_BCAP8 = 7'b000_0010,
    MODE_ACAP8 = 7'b000_0100,
    MODE_PWM = 7'b000_1000,
    MODE_TIMER16 = 7'b001_0000,
    MODE_CAP16 = 7'b010_0000,
    MODE_CMP16 = 7'b100_0000
  } mode_t;
endpackage

// [hdl/pin_sync.sv]
// Three-stage pin synchroniser with edge pulses.
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic lvl_d, rise_d, fall_d;
  // A change is taken only once the second and third stages agree.
  always_comb begin
    lvl_d = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (s2_q == s3_q && s3_q != lvl_q) begin
      lvl_d = s3_q;
      rise_d = s3_q;
      fall_d = ~s3_q;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end
  assign rise = rise_q;
  assign fall = fall_q;
endmodule

// [verif/dtc_chk.sv]
// Port-level assertions for the dual timer, bound to its top module.
`timescale 1ns/1ns
`include "dtc_params.svh"
module dtc_chk (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire dtc_pkg::addr_t ADDR,
  input wire dtc_pkg::byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire dtc_pkg::byte_t RDATA,
  input wire logic TIMER_A_FLAG,
  input wire logic TIMER_B_FLAG,
  input wire logic EXT_A_FLAG,
  input wire logic EXT_B_FLAG,
  input wire logic COMPARE_WAVE_OE_N
);
  import dtc_pkg::*;
  // ----
  // Shadow of the timer B mode register
  // ----
  byte_t bmode_q;
  byte_t bmode_d;
  logic wr_stat;
  assign wr_stat = WR && ADDR == `STAT_ADR;
  always_comb begin
    bmode_d = (WR && ADDR == `B_MODE_ADR) ? WDATA : bmode_q;
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      bmode_q <= 8'h00;
    end else begin
      bmode_q <= bmode_d;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data seen outside the answer cycle");
  a_unmapped_read: assert property (RD && ADDR > `STAT_ADR |=> RDATA == 8'h00)
    else $error("unmapped read returned nonzero data");
  // The enable may be one or two flops behind the port function register.
  a_oe_by_write: assert property ($changed(COMPARE_WAVE_OE_N) |->
    ($past(WR) && $past(ADDR) == `PORTB_ADR) || ($past(WR, 2) && $past(ADDR, 2) == `PORTB_ADR))
    else $error("wave pin enable moved without a port write");
  a_a_flag_clear: assert property ($fell(TIMER_A_FLAG) |-> $past(wr_stat && WDATA[`FL_TA_BIT]))
    else $error("timer A flag dropped without a clear");
  a_b_flag_hold: assert property (TIMER_B_FLAG && !wr_stat |=> TIMER_B_FLAG)
    else $error("timer B flag dropped without a clear");
  a_ext_a_hold: assert property (EXT_A_FLAG && !wr_stat |=> EXT_A_FLAG)
    else $error("external A flag dropped without a clear");
  a_ext_b_clear: assert property ($fell(EXT_B_FLAG) |-> $past(wr_stat && WDATA[`FL_XB_BIT]))
    else $error("external B flag dropped without a clear");
  a_chain_no_b: assert property ($rose(TIMER_B_FLAG) |->
    !($past(bmode_q[`CHAIN_BIT]) && $past(bmode_q[1:0]) == `B_CHAIN_SEL))
    else $error("timer B flag raised while chained");
endmodule
bind dual_timer dtc_chk chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TIMER_A_FLAG(TIMER_A_FLAG), .TIMER_B_FLAG(TIMER_B_FLAG), .EXT_A_FLAG(EXT_A_FLAG),
  .EXT_B_FLAG(EXT_B_FLAG), .COMPARE_WAVE_OE_N(COMPARE_WAVE_OE_N));

// [verif/pin_model.sv]
// Far-side pin model: event clock pulses and capture trigger edges.
`timescale 1ns/1ns
module pin_model (
  input wire logic clk,
  input wire logic slow,
  output logic ev_pin,
  output logic trig_a,
  output logic trig_b
);
  int gap;
  assign gap = slow ? 7 : 2;
  initial begin
    ev_pin = 1'b0;
    trig_a = 1'b0;
    trig_b = 1'b0;
  end
  // Levels are held several clocks so the three-stage synchroniser cannot miss them.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      ev_pin <= !ev_pin;
      repeat (gap) @(posedge clk);
      ev_pin <= !ev_pin;
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic flip();
    @(posedge clk);
    trig_a <= !trig_a;
    trig_b <= !trig_b;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the dual timer with a read scoreboard.
`timescale 1ns/1ns
`include "dtc_params.svh"
module tb_top;
  import dtc_pkg::*;
  logic clk, rst, wr, rd, slow, rd_d;
  logic fa, fb, xa, xb, wave, oe_n, ev, ta, tb;
  addr_t addr;
  byte_t wdata, rdata;
  logic [31:0] lfsr;
  byte_t exp_q[$];
  int err_total, n_compared, n, hi, lo;
  dual_timer uut (.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EVENT_CLOCK_PIN(ev), .CAPTURE_TRIGGER_PIN_A(ta), .CAPTURE_TRIGGER_PIN_B(tb), .TIMER_A_FLAG(fa),
    .TIMER_B_FLAG(fb), .EXT_A_FLAG(xa), .EXT_B_FLAG(xb), .COMPARE_WAVE_PIN(wave), .COMPARE_WAVE_OE_N(oe_n));
  pin_model pins (.clk(clk), .slow(slow), .ev_pin(ev), .trig_a(ta), .trig_b(tb));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr_reg(input addr_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input addr_t a, input byte_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wait_wave(input logic lvl);
    int k;
    k = 0;
    while (wave !== lvl) begin
      @(posedge clk);
      k++;
      if (k > 2000) begin
        chk(16'h0000, 16'h0001);
        print_verdict();
      end
    end
  endtask
  task automatic run_len(input logic lvl, input int lim, output int c);
    c = 0;
    while (wave === lvl && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken one edge later.
  always @(posedge clk) begin
    if (rd_d === 1'b1) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_d <= rd;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    err_total = 0;
    n_compared = 0;
    lfsr = 32'h811b_26da;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Timer B is parked and timer A drained to zero so event counts start from a known value.
    wr_reg(`B_MODE_ADR, 8'h03);
    wr_reg(`A_DATA_ADR, 8'h00);
    idle(600);
    wr_reg(`A_MODE_ADR, 8'h07);
    wr_reg(`A_DATA_ADR, 8'hFF);
    wr_reg(`PORTA_ADR, 8'h00);
    wr_reg(`STAT_ADR, 8'h0F);
    rd_reg(`STAT_ADR, 8'h00);
    lfsr = lfsr_next(lfsr);
    n = int'(lfsr[2:0]) + 2;
    pins.pulse(n);
    idle(8);
    rd_reg(`A_DATA_ADR, 8'(n));
    wr_reg(`PORTA_ADR, 8'h01);
    pins.pulse(2);
    idle(8);
    rd_reg(`A_DATA_ADR, 8'(n));
    wr_reg(`PORTA_ADR, 8'h00);
    wr_reg(`A_DATA_ADR, 8'(n + 2));
    slow <= 1'b1;
    pins.pulse(3);
    slow <= 1'b0;
    idle(8);
    rd_reg(`A_DATA_ADR, 8'h00);
    rd_reg(`STAT_ADR, 8'h01);
    wr_reg(`STAT_ADR, 8'h01);
    rd_reg(`STAT_ADR, 8'h00);
    wr_reg(4'hC, 8'hFF);
    rd_reg(4'hF, 8'h00);
    wr_reg(`A_MODE_ADR, 8'h0F);
    wr_reg(`PORTB_ADR, 8'h0C);
    wr_reg(`EDGE_ADR, 8'h0A);
    pins.pulse(4);
    pins.flip();
    rd_reg(`A_DATA_ADR, 8'h04);
    pins.pulse(2);
    idle(8);
    rd_reg(`A_DATA_ADR, 8'h04);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`EDGE_ADR, 8'(i / 2 * 5));
      wr_reg(`STAT_ADR, 8'h0F);
      pins.flip();
      rd_reg(`STAT_ADR, ((i % 2 == 1 ? i & 4 : i & 2) != 0) ? 8'h0C : 8'h00);
      chk({xb, xa}, ((i % 2 == 1 ? i & 4 : i & 2) != 0) ? 2'h3 : 2'h0);
    end
    wr_reg(`STAT_ADR, 8'h0F);
    pins.pulse(n + 3);
    idle(8);
    rd_reg(`STAT_ADR, 8'h01);
    chk({xb, xa, fb, fa}, 4'h1);
    wr_reg(`PORTB_ADR, 8'h1C);
    wr_reg(`B_MODE_ADR, 8'h00);
    for (int m = 1; m < 5; m += 3) begin
      wr_reg(`B_DATA_ADR, 8'(m));
      idle(300);
      wait_wave(!wave);
      run_len(wave, 2000, n);
      chk(16'(n), 16'(m + 1));
    end
    chk(oe_n, 1'b0);
    chk(fb, 1'b1);
    wr_reg(`PER_LO_ADR, 8'h09);
    wr_reg(`DUTY_LO_ADR, 8'h03);
    wr_reg(`HIGH_ADR, 8'h00);
    wr_reg(`B_MODE_ADR, 8'h30);
    idle(40);
    wait_wave(1'b0);
    wait_wave(1'b1);
    fork
      run_len(1'b1, 2000, hi);
      wr_reg(`DUTY_LO_ADR, 8'h05);
    join
    run_len(1'b0, 2000, lo);
    chk(16'(hi), 16'h0003);
    chk(16'(lo), 16'h0007);
    run_len(1'b1, 2000, hi);
    chk(16'(hi), 16'h0005);
    wr_reg(`PER_LO_ADR, 8'h10);
    wr_reg(`DUTY_LO_ADR, 8'h02);
    wr_reg(`HIGH_ADR, 8'h05);
    idle(600);
    wait_wave(1'b0);
    wait_wave(1'b1);
    run_len(1'b1, 2000, hi);
    run_len(1'b0, 2000, lo);
    chk(16'(hi), 16'h0102);
    chk(16'(lo), 16'h000F);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`HIGH_ADR, 8'h00);
      wr_reg(`PER_LO_ADR, 8'h09);
      wr_reg(`DUTY_LO_ADR, i[1] ? 8'h00 : 8'h09);
      wr_reg(`B_MODE_ADR, i[0] ? 8'h30 : 8'h10);
      idle(60);
      run_len(wave, 40, n);
      chk(16'(n), 16'h0028);
      chk(wave, i[0] ^ i[1]);
    end
    wr_reg(`B_MODE_ADR, 8'h0B);
    wr_reg(`A_DATA_ADR, 8'hFF);
    pins.flip();
    pins.pulse(260);
    idle(8);
    pins.flip();
    rd_reg(`A_DATA_ADR, 8'h04);
    rd_reg(`B_DATA_ADR, 8'h01);
    wr_reg(`B_DATA_ADR, 8'h00);
    wr_reg(`A_DATA_ADR, 8'h03);
    wr_reg(`STAT_ADR, 8'h0F);
    pins.pulse(4);
    idle(8);
    rd_reg(`STAT_ADR, 8'h01);
    chk({fb, fa}, 2'h1);
    idle(4);
    print_verdict();
  end
endmodule
